// *** src/converter_back_end.v ***
// Sync monitor, bypass data path and downconverter control of the converter
// Operation
// - Bypass: fixed latency, sync resets ramp pattern
// - Downconverter mode: sync resets dividers and phase
// - Pin zero is sync input when config 0x00
// - Sync mask selects which blocks get reset
// - Sync captured at tap sixty ps after edge
// - Monitor flags transitions from -60 to +140ps
// - Five window flags, each forty ps wide
// - Monitor status refreshed on each sync rise
// - Edge-seen bit sticky until software clears it
// - Status register layout: zero, seen, any, windows
// - Time stamp registers sync rise per sample
// - Stamp enabled by 0xC0, replaces lane zero LSB
// - Data latency 43, stamp latency 8 cycles
// - Overrange on max code, no later than data
// - Overrange on pins, split or ORed
// - Overrange may replace each channel word LSB
// - Per-channel signed gain, one plus code over 128
// - Crosspoint feeds each downconverter from A, B, average
// - Dual /2 to /32768, quad minimum /4
// - Real decimation single band, complex any band
// - Common factor field; complex enable bit selects complex
// - Unequal ratios: slower samples repeat in stream
`timescale 1ns/1ps
`include "converter_defines.vh"
module converter_back_end (
	input  wire        clk,
	input  wire        resetn,
	input  wire [11:0] regAddr,
	input  wire [7:0]  regWrData,
	input  wire        regWrite,
	input  wire        regRead,
	output wire [7:0]  regRdData,
	output wire        regRdValid,
	input  wire [15:0] firstInputChannel,
	input  wire [15:0] secondInputChannel,
	input  wire [5:0]  syncTaps,
	output wire        generalPinZeroOut,
	output wire        generalPinZeroOe,
	output wire        generalPinOneOut,
	output wire        generalPinOneOe,
	output wire [15:0] laneFirst,
	output wire [15:0] laneSecond,
	output wire [33:0] streamData,
	output wire        streamValid,
	input  wire        streamReady
);
	// ****************************************
	// Functions
	// ****************************************
	function [16:0] applyGain;
		input [15:0] x;
		input [7:0]  g;
		reg signed [23:0] p;
		reg signed [17:0] s;
		reg               sat;
		begin
			p = $signed(x) * $signed(g);
			s = $signed({{2{x[15]}}, x}) + $signed({p[23], p[23:`GAIN_SHIFT]});
			sat = (x == 16'h7FFF) || (x == 16'h8000);
			if (s > $signed(18'h0_7FFF))
				applyGain = {1'b1, 16'h7FFF};
			else if (s < $signed(18'h3_8000))
				applyGain = {1'b1, 16'h8000};
			else
				applyGain = {sat, s[15:0]};
		end
	endfunction

	function [15:0] codeMask;
		input [3:0] code;
		begin
			codeMask = (16'h0001 << code) - 16'h0001;
		end
	endfunction

	function [31:0] mixWord;
		input [15:0] s;
		input [1:0]  ph;
		input        cplx;
		reg   [15:0] neg;
		begin
			neg = 16'h0000 - s;
			// Square-wave oscillator keeps area small
			mixWord[15:0]  = ph[1] ? neg : s;
			mixWord[31:16] = !cplx ? 16'h0000 : ((ph[1] ^ ph[0]) ? neg : s);
		end
	endfunction

	// ****************************************
	// Configuration registers
	// ****************************************
	reg [7:0] pinCfg_q;
	reg [7:0] ovrLsb_q;
	reg [7:0] gainFirst_q;
	reg [7:0] gainSecond_q;
	reg [7:0] syncMask_q;
	reg [7:0] outMode_q;
	reg [7:0] xpoint_q;
	reg [7:0] decLow_q;
	reg [7:0] decHigh_q;
	reg [7:0] decCommon_q;
	reg [6:0] syncStat_q;
	reg [7:0] rdData_q;
	reg       rdValid_q;
	reg [7:0] rdMux;
	wire      wrStat = regWrite && (regAddr == `REG_SYNC_STATUS);

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pinCfg_q     <= `RST_PIN_CONFIG;
			ovrLsb_q     <= `RST_ZERO;
			gainFirst_q  <= `RST_ZERO;
			gainSecond_q <= `RST_ZERO;
			syncMask_q   <= `RST_SYNC_MASK;
			outMode_q    <= `RST_ZERO;
			xpoint_q     <= `RST_CROSSPOINT;
			decLow_q     <= `RST_ZERO;
			decHigh_q    <= `RST_ZERO;
			decCommon_q  <= `RST_ZERO;
		end
		else if (regWrite)
		begin
			case (regAddr)
			`REG_PIN_CONFIG:  pinCfg_q     <= regWrData;
			`REG_OVR_LSB:     ovrLsb_q     <= regWrData;
			`REG_GAIN_FIRST:  gainFirst_q  <= regWrData;
			`REG_GAIN_SECOND: gainSecond_q <= regWrData;
			`REG_SYNC_MASK:   syncMask_q   <= regWrData;
			`REG_OUTPUT_MODE: outMode_q    <= regWrData;
			`REG_CROSSPOINT:  xpoint_q     <= regWrData;
			`REG_DEC_LOW:     decLow_q     <= regWrData;
			`REG_DEC_HIGH:    decHigh_q    <= regWrData;
			`REG_DEC_COMMON:  decCommon_q  <= regWrData;
			default:          pinCfg_q     <= pinCfg_q;
			endcase
		end
	end

	always @*
	begin
		case (regAddr)
		`REG_SYNC_STATUS: rdMux = {1'b0, syncStat_q};
		`REG_PIN_CONFIG:  rdMux = pinCfg_q;
		`REG_OVR_LSB:     rdMux = ovrLsb_q;
		`REG_GAIN_FIRST:  rdMux = gainFirst_q;
		`REG_GAIN_SECOND: rdMux = gainSecond_q;
		`REG_SYNC_MASK:   rdMux = syncMask_q;
		`REG_OUTPUT_MODE: rdMux = outMode_q;
		`REG_CROSSPOINT:  rdMux = xpoint_q;
		`REG_DEC_LOW:     rdMux = decLow_q;
		`REG_DEC_HIGH:    rdMux = decHigh_q;
		`REG_DEC_COMMON:  rdMux = decCommon_q;
		default:          rdMux = 8'h00;
		endcase
	end

	// Read has no side effect on any status bit
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdData_q  <= 8'h00;
			rdValid_q <= 1'b0;
		end
		else
		begin
			rdValid_q <= regRead;
			if (regRead)
				rdData_q <= rdMux;
		end
	end

	// ****************************************
	// Sync capture and window monitor
	// ****************************************
	reg        syncPrev_q;
	wire       syncSel   = (pinCfg_q == `PIN_SYNC);
	wire       syncLevel = syncTaps[`SYNC_CAPTURE_TAP];
	wire       syncRise  = syncSel && syncLevel && !syncPrev_q;
	// Adjacent delay taps that disagree mark where the edge fell
	wire [4:0] winFlags  = syncTaps[4:0] ^ syncTaps[5:1];
	wire       bypass    = (decCommon_q[3:0] == 4'h0);

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			syncPrev_q <= 1'b0;
			syncStat_q <= 7'h00;
		end
		else
		begin
			syncPrev_q <= syncLevel;
			if (syncRise)
			begin
				syncStat_q[4:0]              <= winFlags;
				syncStat_q[`STAT_ANY_WINDOW] <= |winFlags;
			end
			// Set beats a clear landing in the same cycle
			if (syncRise)
				syncStat_q[`STAT_EDGE_SEEN] <= 1'b1;
			else if (wrStat && regWrData[`STAT_EDGE_SEEN])
				syncStat_q[`STAT_EDGE_SEEN] <= 1'b0;
		end
	end

	// ****************************************
	// Bypass data path
	// ****************************************
	reg  [15:0] ramp_q;
	reg  [33:0] gain_q;
	reg  [33:0] dly_q [0:`DATA_LATENCY-3];
	reg  [6:0]  stamp_q;
	reg  [15:0] laneFirst_q;
	reg  [15:0] laneSecond_q;
	reg         pinZero_q;
	reg         pinZeroOe_q;
	reg         pinOne_q;
	reg         pinOneOe_q;
	wire        rampEn   = syncMask_q[`MASK_RAMP_EN];
	wire        stampEn  = outMode_q[`MODE_STAMP_HI] && outMode_q[`MODE_STAMP_LO] && bypass;
	wire [15:0] srcFirst  = rampEn ? ramp_q : firstInputChannel;
	wire [15:0] srcSecond = rampEn ? ramp_q : secondInputChannel;
	wire [16:0] gFirst   = applyGain(srcFirst, gainFirst_q);
	wire [16:0] gSecond  = applyGain(srcSecond, gainSecond_q);
	wire        ovrInLsb = ovrLsb_q[0];
	wire [33:0] dlyOut   = dly_q[`DATA_LATENCY-3];
	integer     k;

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ramp_q       <= 16'h0000;
			gain_q       <= 34'h0_0000_0000;
			stamp_q      <= 7'h00;
			laneFirst_q  <= 16'h0000;
			laneSecond_q <= 16'h0000;
			pinZero_q    <= 1'b0;
			pinZeroOe_q  <= 1'b0;
			pinOne_q     <= 1'b0;
			pinOneOe_q   <= 1'b0;
			for (k = 0; k < `DATA_LATENCY-2; k = k + 1)
				dly_q[k] <= 34'h0_0000_0000;
		end
		else
		begin
			if (syncRise && bypass && syncMask_q[`MASK_RAMP])
				ramp_q <= 16'h0000;
			else
				ramp_q <= ramp_q + 16'h0001;
			// Overrange bit travels beside its sample, so it never trails the data
			gain_q <= {gSecond[16], gFirst[16],
				gSecond[15:1], ovrInLsb ? gSecond[16] : gSecond[0],
				gFirst[15:1], ovrInLsb ? gFirst[16] : gFirst[0]};
			dly_q[0] <= gain_q;
			for (k = 1; k < `DATA_LATENCY-2; k = k + 1)
				dly_q[k] <= dly_q[k-1];
			stamp_q <= {stamp_q[5:0], syncRise && stampEn};
			// Stamp bypasses the long delay: it leads its sample by 35 cycles
			laneFirst_q  <= !bypass ? 16'h0000 :
				{dlyOut[15:1], stampEn ? stamp_q[`STAMP_LATENCY-2] : dlyOut[0]};
			laneSecond_q <= bypass ? dlyOut[31:16] : 16'h0000;
			case (pinCfg_q)
			`PIN_OVR_SPLIT:
			begin
				pinZero_q   <= dlyOut[32];
				pinZeroOe_q <= 1'b1;
				pinOne_q    <= dlyOut[33];
				pinOneOe_q  <= 1'b1;
			end
			`PIN_OVR_OR:
			begin
				pinZero_q   <= dlyOut[32] | dlyOut[33];
				pinZeroOe_q <= 1'b1;
				pinOne_q    <= 1'b0;
				pinOneOe_q  <= 1'b0;
			end
			default:
			begin
				pinZero_q   <= 1'b0;
				pinZeroOe_q <= 1'b0;
				pinOne_q    <= 1'b0;
				pinOneOe_q  <= 1'b0;
			end
			endcase
		end
	end

	// ****************************************
	// Downconverter control
	// ****************************************
	reg  [15:0] divCnt_q;
	reg  [15:0] phase_q [0:3];
	reg  [31:0] held_q  [0:3];
	reg  [31:0] snap_q  [0:3];
	reg  [3:0]  effCode [0:3];
	reg  [15:0] ddcSrc  [0:3];
	reg  [3:0]  tick;
	reg  [3:0]  minCode;
	reg  [1:0]  seqIdx_q;
	reg         seqBusy_q;
	reg         slotPend_q;
	wire        cplx     = outMode_q[`MODE_COMPLEX];
	wire        quad     = decCommon_q[`DEC_QUAD];
	// Real output is held to one band
	wire [1:0]  lastDdc  = !cplx ? 2'd0 : (quad ? 2'd3 : 2'd1);
	// Sign-extended sum, so the mean of two negative words stays negative
	wire [16:0] avgSum   = {gain_q[15], gain_q[15:0]} + {gain_q[31], gain_q[31:16]};
	wire [15:0] average  = avgSum[16:1];
	wire [7:0]  srcSel   = xpoint_q;
	wire [7:0]  perDdc   [0:3];
	wire        fifoReady;
	wire        pushValid = seqBusy_q;
	integer     i;

	assign perDdc[0] = {4'h0, decLow_q[3:0]};
	assign perDdc[1] = {4'h0, decLow_q[7:4]};
	assign perDdc[2] = {4'h0, decHigh_q[3:0]};
	assign perDdc[3] = {4'h0, decHigh_q[7:4]};

	always @*
	begin
		minCode = 4'hF;
		tick    = 4'h0;
		for (i = 0; i < 4; i = i + 1)
		begin
			effCode[i] = (perDdc[i][3:0] != 4'h0) ? perDdc[i][3:0] : decCommon_q[3:0];
			if (quad && effCode[i] < `QUAD_MIN_CODE)
				effCode[i] = `QUAD_MIN_CODE;
			case (srcSel[2*i +: 2])
			2'h0:         ddcSrc[i] = gain_q[15:0];
			`SRC_SECOND:  ddcSrc[i] = gain_q[31:16];
			`SRC_AVERAGE: ddcSrc[i] = average;
			default:      ddcSrc[i] = gain_q[15:0];
			endcase
			tick[i] = ((divCnt_q & codeMask(effCode[i])) == codeMask(effCode[i]));
			if (i <= lastDdc && effCode[i] < minCode)
				minCode = effCode[i];
		end
	end

	// Slot rate follows the fastest active band
	wire slot = !bypass && ((divCnt_q & codeMask(minCode)) == codeMask(minCode));

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			divCnt_q   <= 16'h0000;
			seqIdx_q   <= 2'd0;
			seqBusy_q  <= 1'b0;
			slotPend_q <= 1'b0;
			for (i = 0; i < 4; i = i + 1)
			begin
				phase_q[i] <= 16'h0000;
				held_q[i]  <= 32'h0000_0000;
				snap_q[i]  <= 32'h0000_0000;
			end
		end
		else
		begin
			if (syncRise && !bypass && syncMask_q[`MASK_DIVIDER])
				divCnt_q <= 16'h0000;
			else
				divCnt_q <= divCnt_q + 16'h0001;
			slotPend_q <= slot;
			for (i = 0; i < 4; i = i + 1)
			begin
				if (syncRise && !bypass && syncMask_q[`MASK_PHASE])
					phase_q[i] <= 16'h0000;
				else
					phase_q[i] <= phase_q[i] + {12'h000, i[1:0], 2'b01};
				// Slower bands keep their word until their own divider ticks
				if (tick[i])
					held_q[i] <= mixWord(ddcSrc[i], phase_q[i][15:14], cplx);
			end
			// A slot arriving mid-walk is dropped; the last push chains into it to keep the rate
			if (slotPend_q && (!seqBusy_q || (fifoReady && seqIdx_q == lastDdc)))
			begin
				for (i = 0; i < 4; i = i + 1)
					snap_q[i] <= held_q[i];
				seqBusy_q <= 1'b1;
				seqIdx_q  <= 2'd0;
			end
			else if (seqBusy_q && fifoReady)
			begin
				seqIdx_q <= seqIdx_q + 2'd1;
				if (seqIdx_q == lastDdc)
					seqBusy_q <= 1'b0;
			end
		end
	end

	stream_fifo #(
		.WIDTH (34),
		.DEPTH (8),
		.AW    (3)
	) u_fifo (
		.clk      (clk),
		.resetn   (resetn),
		.inData   ({seqIdx_q, snap_q[seqIdx_q]}),
		.inValid  (pushValid),
		.inReady  (fifoReady),
		.outData  (streamData),
		.outValid (streamValid),
		.outReady (streamReady)
	);

	assign regRdData         = rdData_q;
	assign regRdValid        = rdValid_q;
	assign laneFirst         = laneFirst_q;
	assign laneSecond        = laneSecond_q;
	assign generalPinZeroOut = pinZero_q;
	assign generalPinZeroOe  = pinZeroOe_q;
	assign generalPinOneOut  = pinOne_q;
	assign generalPinOneOe   = pinOneOe_q;
endmodule

// *** src/converter_defines.vh ***
// Register offsets, field positions, reset values and timing counts
`ifndef CONVERTER_DEFINES_VH
`define CONVERTER_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define REG_SYNC_STATUS       12'h140
`define REG_PIN_CONFIG        12'h146
`define REG_OVR_LSB           12'h116
`define REG_GAIN_FIRST        12'h15B
`define REG_GAIN_SECOND       12'h15C
`define REG_SYNC_MASK         12'h161
`define REG_OUTPUT_MODE       12'h162
`define REG_CROSSPOINT        12'h163
`define REG_DEC_LOW           12'h167
`define REG_DEC_HIGH          12'h168
`define REG_DEC_COMMON        12'h169

// ****************************************
// Field positions and encodings
// ****************************************
`define STAT_EDGE_SEEN        6
`define STAT_ANY_WINDOW       5
`define MASK_RAMP             0
`define MASK_DIVIDER          1
`define MASK_PHASE            2
`define MASK_RAMP_EN          7
`define MODE_STAMP_HI         7
`define MODE_STAMP_LO         6
`define MODE_COMPLEX          2
`define DEC_QUAD              4
`define PIN_SYNC              8'h00
`define PIN_OVR_SPLIT         8'h01
`define PIN_OVR_OR            8'h02
`define SRC_SECOND            2'h1
`define SRC_AVERAGE           2'h2

// ****************************************
// Reset values
// ****************************************
`define RST_PIN_CONFIG        8'h01
`define RST_CROSSPOINT        8'h50
`define RST_SYNC_MASK         8'h07
`define RST_ZERO              8'h00

// ****************************************
// Timing
// ****************************************
`define SYNC_TAP_FIRST_PS     (-60)
`define SYNC_TAP_STEP_PS      40
`define SYNC_CAPTURE_OFFSET_PS 60
`define SYNC_CAPTURE_TAP      ((`SYNC_CAPTURE_OFFSET_PS - `SYNC_TAP_FIRST_PS) / `SYNC_TAP_STEP_PS)
`define DATA_LATENCY          43
`define STAMP_LATENCY         8
`define QUAD_MIN_CODE         4'h2
`define GAIN_SHIFT            7

`endif

// *** src/stream_fifo.v ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module stream_fifo #(
	parameter WIDTH = 34,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clk,
	input  wire             resetn,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output wire [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wrPtr_q;
	reg [AW-1:0]    rdPtr_q;
	reg [AW:0]      count_q;
	wire            doPush;
	wire            doPop;

	assign inReady  = (count_q != DEPTH[AW:0]);
	assign outValid = (count_q != {(AW+1){1'b0}});
	assign outData  = mem[rdPtr_q];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	always @(posedge clk)
	begin
		if (doPush)
			mem[wrPtr_q] <= inData;
	end

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (doPush)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (doPop)
				rdPtr_q <= rdPtr_q + 1'b1;
			if (doPush && !doPop)
				count_q <= count_q + 1'b1;
			else if (doPop && !doPush)
				count_q <= count_q - 1'b1;
		end
	end
endmodule

// *** testbench/converter_back_end_props.sv ***
// Port-level assertions for the converter back end
`timescale 1ns/1ps
`include "converter_defines.vh"
module converter_back_end_props (
	input wire        clk,
	input wire        resetn,
	input wire [11:0] regAddr,
	input wire [7:0]  regWrData,
	input wire        regWrite,
	input wire        regRead,
	input wire [7:0]  regRdData,
	input wire        regRdValid,
	input wire [15:0] firstInputChannel,
	input wire [15:0] secondInputChannel,
	input wire [5:0]  syncTaps,
	input wire        generalPinZeroOut,
	input wire        generalPinZeroOe,
	input wire        generalPinOneOut,
	input wire        generalPinOneOe,
	input wire [15:0] laneFirst,
	input wire [15:0] laneSecond,
	input wire [33:0] streamData,
	input wire        streamValid,
	input wire        streamReady
);
	// ****************************************
	// Shadow of written configuration
	// ****************************************
	reg [7:0] pin_q, mode_q, dec_q, lsb_q, gain_q, age_q;
	reg [4:0] win_q;
	reg       seen_q, prev_q;
	wire      rise = syncTaps[3] && !prev_q && pin_q == `PIN_SYNC;
	wire      wr = regWrite;
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			{pin_q, mode_q, dec_q, lsb_q, gain_q, age_q} <= {`RST_PIN_CONFIG, 40'h0};
			{win_q, seen_q, prev_q} <= 7'h00;
		end
		else
		begin
			prev_q <= syncTaps[3];
			// Age gates checks until a new setting has flushed the pipeline
			age_q <= wr ? 8'h00 : age_q + 8'(age_q != 8'hFF);
			if (wr && regAddr == `REG_PIN_CONFIG) pin_q <= regWrData;
			if (wr && regAddr == `REG_OUTPUT_MODE) mode_q <= regWrData;
			if (wr && regAddr == `REG_DEC_COMMON) dec_q <= regWrData;
			if (wr && regAddr == `REG_OVR_LSB) lsb_q <= regWrData;
			if (wr && regAddr == `REG_GAIN_FIRST) gain_q <= regWrData;
			if (rise) win_q <= syncTaps[4:0] ^ syncTaps[5:1];
			if (rise || (wr && regAddr == `REG_SYNC_STATUS && regWrData[6])) seen_q <= rise;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence statusRead;
		regRead && regAddr == `REG_SYNC_STATUS;
	endsequence
	sequence stampRise;
		rise && mode_q[7:6] == 2'b11 && dec_q[3:0] == 4'h0;
	endsequence
	AST_STATUS: assert property (statusRead |=> regRdData == {1'b0, $past(seen_q), |$past(win_q), $past(win_q)})
		else $error("status read differs");
	AST_DATA_LAT: assert property (age_q >= 8'h3C && gain_q == 8'h00 && !lsb_q[0] && mode_q[7:6] != 2'b11 && dec_q[3:0] == 4'h0 |-> laneFirst == $past(firstInputChannel, 43))
		else $error("bypass data latency wrong");
	AST_OVR_LAT: assert property (age_q >= 8'h32 && pin_q == `PIN_OVR_SPLIT && firstInputChannel == 16'h7FFF |-> ##43 generalPinZeroOut)
		else $error("overrange pin late");
	AST_SYNC_PIN: assert property (age_q >= 8'h03 && pin_q == `PIN_SYNC |-> !generalPinZeroOe)
		else $error("sync pin driven");
	AST_SPLIT_PINS: assert property (age_q >= 8'h03 && pin_q == `PIN_OVR_SPLIT |-> generalPinZeroOe && generalPinOneOe)
		else $error("overrange pins not driven");
	AST_STAMP: assert property (stampRise |-> ##8 laneFirst[0])
		else $error("stamp missing");
	AST_DEC_LANES: assert property (age_q >= 8'h30 && dec_q[3:0] != 4'h0 |-> laneFirst == 16'h0000 && laneSecond == 16'h0000)
		else $error("lanes active in decimation");
	AST_STREAM_HOLD: assert property (streamValid && !streamReady |=> streamValid && $stable(streamData))
		else $error("stream head moved while stalled");
endmodule
bind converter_back_end converter_back_end_props i_props (.clk, .resetn, .regAddr, .regWrData, .regWrite, .regRead,
	.regRdData, .regRdValid, .firstInputChannel, .secondInputChannel, .syncTaps, .generalPinZeroOut,
	.generalPinZeroOe, .generalPinOneOut, .generalPinOneOe, .laneFirst, .laneSecond, .streamData, .streamValid,
	.streamReady);

// *** testbench/capture_partner.sv ***
// Far-side model: sync pulse source and stalling stream sink
`timescale 1ns/1ps
module capture_partner (
	input  wire        clk,
	output logic [5:0] syncTaps,
	input  wire [33:0] streamData,
	input  wire        streamValid,
	output logic       streamReady
);
	logic [33:0] got [$];
	logic        stall = 1'b0;
	initial syncTaps = 6'h00;
	initial streamReady = 1'b0;
	// ****************************************
	// Sink and pulse source
	// ****************************************
	always @(posedge clk)
	begin
		if (streamValid && streamReady)
			got.push_back(streamData);
		streamReady <= #1 !stall;
	end
	// Single pulse; whole word drops at once so the fall adds no rise
	task automatic syncPulse(input logic [5:0] edgeTaps);
		syncTaps = edgeTaps;
		@(posedge clk);
		#1 syncTaps = 6'h3F;
		repeat (3) @(posedge clk);
		#1 syncTaps = 6'h00;
	endtask
endmodule

// *** testbench/converter_back_end_tb_top.sv ***
// Self-checking bench for the converter back end
`timescale 1ns/1ps
module converter_back_end_tb_top;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [11:0] regAddr = 12'h000;
	logic [7:0]  regWrData = 8'h00;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic [15:0] manA = 16'h7FFF;
	logic [15:0] manB = 16'h0000;
	logic [15:0] ramp = 16'h0000;
	logic        freeRun = 1'b0;
	wire  [15:0] firstInputChannel = freeRun ? ramp : manA;
	wire  [15:0] secondInputChannel = freeRun ? ~ramp : manB;
	wire  [7:0]  regRdData;
	wire         regRdValid, generalPinZeroOut, generalPinZeroOe, generalPinOneOut, generalPinOneOe;
	wire  [5:0]  syncTaps;
	wire  [15:0] laneFirst, laneSecond;
	wire  [33:0] streamData;
	wire         streamValid, streamReady;
	int          n_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          start;
	int          rep [2] = '{0, 0};
	logic [11:0] rstAddr [7] = '{12'h146, 12'h163, 12'h161, 12'h15B, 12'h15C, 12'h140, 12'h000};
	logic [7:0]  rstVal [7] = '{8'h01, 8'h50, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  modeTab [3] = '{8'h00, 8'h04, 8'h04};
	logic [7:0]  decTab [3] = '{8'h02, 8'h02, 8'h12};
	int          ddcTab [3] = '{1, 2, 4};
	converter_back_end i_dut (.clk, .resetn, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .regRdValid,
		.firstInputChannel, .secondInputChannel, .syncTaps, .generalPinZeroOut, .generalPinZeroOe,
		.generalPinOneOut, .generalPinOneOe, .laneFirst, .laneSecond, .streamData, .streamValid, .streamReady);
	capture_partner i_partner (.clk, .syncTaps, .streamData, .streamValid, .streamReady);
	// ****************************************
	// Clock, input ramp, hang guard
	// ****************************************
	initial forever #5 clk = ~clk;
	always @(posedge clk)
	begin
		ramp <= #1 ramp + 16'h0123;
		cycles++;
		if (cycles == 5000)
		begin
			n_errors++;
			final_report();
		end
	end
	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Idle cycle after each write keeps strobes from toggling twice in a step
	task automatic regWr(input logic [11:0] a, input logic [7:0] d);
		regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		@(posedge clk);
		#1 regWrite = 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic regRd(input logic [11:0] a, input logic [7:0] exp);
		regAddr = a;
		regRead = 1'b1;
		@(posedge clk);
		#1 regRead = 1'b0;
		check("read valid", 34'(regRdValid), 34'h1);
		check($sformatf("reg %h", a), 34'(regRdData), 34'(exp));
		@(posedge clk);
		#1;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		#1 resetn = 1'b1;
		for (int i = 0; i < 7; i++)
			regRd(rstAddr[i], rstVal[i]);
		repeat (60) @(posedge clk);
		#1 $display("test reset values done");
		regWr(12'h15B, 8'h40);
		regWr(12'h15C, 8'hC0);
		regRd(12'h15B, 8'h40);
		regRd(12'h15C, 8'hC0);
		regWr(12'h140, 8'hBF);
		regRd(12'h140, 8'h00);
		$display("test registers done");
		regWr(12'h116, 8'h01);
		regWr(12'h146, 8'h02);
		manA = 16'h0000;
		repeat (45) @(posedge clk);
		#1 manA = 16'h1000;
		manB = 16'h8000;
		@(posedge clk);
		#1 manA = 16'h0000;
		manB = 16'h0000;
		repeat (41) @(posedge clk);
		#1 check("lane early", 34'(laneFirst), 34'h0);
		check("pin early", 34'(generalPinZeroOut), 34'h0);
		@(posedge clk);
		#1 check("lane first", 34'(laneFirst), 34'h1800);
		check("lane second", 34'(laneSecond), 34'hC001);
		check("pins", 34'({generalPinZeroOut, generalPinZeroOe, generalPinOneOe}), 34'h6);
		$display("test bypass data done");
		regWr(12'h146, 8'h00);
		for (int k = 1; k < 4; k++)
		begin
			i_partner.syncPulse(6'h3F << k);
			regRd(12'h140, 8'h60 | (8'h01 << (k - 1)));
			regRd(12'h140, 8'h60 | (8'h01 << (k - 1)));
			regWr(12'h140, 8'h40);
			regRd(12'h140, 8'h20 | (8'h01 << (k - 1)));
		end
		check("pin0 enable", 34'(generalPinZeroOe), 34'h0);
		$display("test sync monitor done");
		regWr(12'h162, 8'hC0);
		i_partner.syncPulse(6'h3C);
		repeat (3) @(posedge clk);
		#1 check("stamp early", 34'(laneFirst[0]), 34'h0);
		@(posedge clk);
		#1 check("stamp", 34'(laneFirst[0]), 34'h1);
		regWr(12'h162, 8'h00);
		$display("test time stamp done");
		regWr(12'h15B, 8'h00);
		regWr(12'h116, 8'h00);
		regWr(12'h161, 8'h87);
		i_partner.syncPulse(6'h38);
		repeat (40) @(posedge clk);
		#1 check("ramp restart", 34'(laneFirst), 34'h0);
		regWr(12'h161, 8'h07);
		$display("test ramp done");
		freeRun = 1'b1;
		repeat (100) @(posedge clk);
		#1;
		for (int m = 0; m < 3; m++)
		begin
			regWr(12'h162, modeTab[m]);
			regWr(12'h169, decTab[m]);
			i_partner.stall = (m == 1);
			repeat (100) @(posedge clk);
			#1 if (m == 1) check("held head", 34'(streamValid), 34'h1);
			i_partner.stall = 1'b0;
			repeat (40) @(posedge clk);
			#1 i_partner.got.delete();
			repeat (80) @(posedge clk);
			#1 start = 0;
			while (start < 4 && i_partner.got[start][33:32] != 2'h0)
				start++;
			for (int j = 0; j < 12; j++)
			begin
				check("ddc order", 34'(i_partner.got[start + j][33:32]), 34'(j % ddcTab[m]));
				if (m == 0) check("real q", 34'(i_partner.got[start + j][31:16]), 34'h0);
			end
		end
		$display("test stream modes done");
		regWr(12'h169, 8'h02);
		regWr(12'h167, 8'h32);
		repeat (40) @(posedge clk);
		#1 i_partner.got.delete();
		repeat (100) @(posedge clk);
		#1 foreach (i_partner.got[i])
			if (i > 1 && i_partner.got[i] === i_partner.got[i - 2])
				rep[i_partner.got[i][32]]++;
		check("fast repeats", 34'(rep[0]), 34'h0);
		check("slow repeats", 34'(rep[1] > 3), 34'h1);
		$display("test unequal ratios done");
		final_report();
	end
endmodule
